// ==== design/rtc_power_timebase_map.vh ====
`ifndef RTC_POWER_TIMEBASE_MAP_VH
`define RTC_POWER_TIMEBASE_MAP_VH

// clock rate in Hz (40 MHz)
`define CLK_HZ              40000000
// one-second tick period in clock cycles
`define SEC_CYCLES          40000000
// backup-supply correction and conversion interval, seconds
`define BACKUP_INTERVAL_S   4'hA
// main-supply interval, seconds
`define MAIN_INTERVAL_S     4'h1
// startup delay before first measurement, seconds
`define STARTUP_DELAY_S     4'h2
// reset hold after supply recovery, milliseconds
`define RECOVERY_HOLD_MS    250
// reset hold in cycles, rounded down
`define RECOVERY_HOLD_CYC   (`RECOVERY_HOLD_MS * (`CLK_HZ / 1000))
// calendar defaults, BCD
`define CAL_SEC_RST         8'h00
`define CAL_MIN_RST         8'h00
`define CAL_HOUR_RST        8'h00
`define CAL_DOW_RST         8'h01
`define CAL_DATE_RST        8'h01
`define CAL_MONTH_RST       8'h01
`define CAL_YEAR_RST        8'h00
// trim word width
`define TRIM_W              10

`endif

// ==== design/trim_adder.v ====
`timescale 1ns/1ps
`include "rtc_power_timebase_map.vh"

// saturating sum of factory trim, aging offset and temperature term
module trim_adder (
	// operands
	input  wire signed [9:0] i_factory_trim,
	input  wire signed [7:0] i_aging_offset,
	input  wire signed [9:0] i_temp_term,
	// result
	output wire signed [9:0] o_trim
);
	wire signed [11:0] sum;

	assign sum = {{2{i_factory_trim[9]}}, i_factory_trim} + {{4{i_aging_offset[7]}}, i_aging_offset}
		+ {{2{i_temp_term[9]}}, i_temp_term};
	// clamp instead of wrapping: a wrap would flip the sign of the correction
	assign o_trim = (sum > 12'sd511) ? 10'sh1FF : (sum < -12'sd512) ? 10'sh200 : sum[9:0];
endmodule // trim_adder

// ==== design/rtc_power_timebase_control.v ====
`timescale 1ns/1ps
`include "rtc_power_timebase_map.vh"

// Contract
// - Correction of the 1Hz base runs every second on main supply and every ten seconds on backup.
// - The temperature result is read and folded into the correction of the 1Hz tick.
// - A signed aging offset is added to the factory trim value.
// - Main supply is used when above the fail threshold or above backup, else backup is used.
// - The active-low reset output is driven low while main supply is below the fail threshold.
// - With main supply absent in backup-only use the reset output is disabled and sits low.
// - Temperature conversion runs every second on main supply and every ten seconds on backup.
// - On first backup power the oscillator stays stopped until main supply is good or an address write.
// - About two seconds after main supply or an address write a measurement and correction occur.
// - Once started the oscillator runs with periodic correction while either supply is valid.
// - First main supply or an address write on backup loads the calendar with 01/01/00 01 00:00:00.
// - Oscillator disable under backup stops the oscillator in a data-retention mode.
// - After main supply recovers the reset is held low about 250ms, or released at once if stopped.
module rtc_power_timebase_control #(
	parameter SEC_CYCLES   = `SEC_CYCLES,
	parameter RECOVERY_CYC = `RECOVERY_HOLD_CYC
) (
	// clock, reset, enable
	input  wire              I_CLK,
	input  wire              I_RESETN,
	input  wire              I_CE,
	// supply comparators (asynchronous)
	input  wire              I_MAIN_ABOVE_PF,
	input  wire              I_MAIN_ABOVE_BACKUP,
	input  wire              I_MAIN_PRESENT,
	input  wire              I_BACKUP_VALID,
	// host side, same clock
	input  wire              I_ADDR_WRITE,
	input  wire              I_OSC_DISABLE_CTL,
	input  wire signed [7:0] I_AGING_OFFSET,
	input  wire signed [9:0] I_FACTORY_TRIM,
	// temperature sensor
	input  wire              I_TEMP_DONE,
	input  wire signed [9:0] I_TEMP_TERM,
	// supply and reset
	output reg               O_USE_MAIN,
	output reg               O_RESET_N,
	output reg               O_RESET_OE,
	// oscillator and time base
	output reg               O_OSC_RUN,
	output reg               O_TICK_1HZ,
	output reg               O_TEMP_START,
	output reg               O_TRIM_LOAD,
	output reg  signed [9:0] O_TRIM,
	// calendar default load
	output reg               O_CAL_LOAD,
	output reg         [7:0] O_CAL_SEC,
	output reg         [7:0] O_CAL_MIN,
	output reg         [7:0] O_CAL_HOUR,
	output reg         [7:0] O_CAL_DOW,
	output reg         [7:0] O_CAL_DATE,
	output reg         [7:0] O_CAL_MONTH,
	output reg         [7:0] O_CAL_YEAR
);
	localparam [2:0] ST_WAIT  = 3'h1;
	localparam [2:0] ST_RUN   = 3'h2;
	localparam [2:0] ST_RETAIN = 3'h4;

	// comparator synchronisers
	reg  [3:0] sync_a;
	reg  [3:0] sync_b;
	wire       above_pf   = sync_b[0];
	wire       above_bat  = sync_b[1];
	wire       main_in    = sync_b[2];
	wire       bat_ok     = sync_b[3];

	reg  [2:0]  state;
	reg  [2:0]  next_state;
	reg  [31:0] sec_cnt;
	reg  [3:0]  interval_cnt;
	reg  [3:0]  startup_cnt;
	reg         startup_pend;
	reg         main_seen;
	reg  [31:0] hold_cnt;
	reg         corr_pend;
	reg         prev_pf;
	wire        use_main;
	wire        sec_wrap;
	wire        supply_ok;
	wire [3:0]  interval;
	wire signed [9:0] sum_trim;

	// counter at limit test, reused for second and hold timers
	function at_limit;
		input [31:0] cnt;
		input [31:0] lim;
		begin
			at_limit = (cnt >= lim - 32'h00000001);
		end
	endfunction

	assign use_main  = above_pf | (main_in & above_bat);
	assign supply_ok = main_in | bat_ok;
	assign sec_wrap  = (state == ST_RUN) && at_limit(sec_cnt, SEC_CYCLES);
	assign interval  = use_main ? `MAIN_INTERVAL_S : `BACKUP_INTERVAL_S;

	trim_adder u_trim (
		.i_factory_trim (I_FACTORY_TRIM),
		.i_aging_offset (I_AGING_OFFSET),
		.i_temp_term    (I_TEMP_TERM),
		.o_trim         (sum_trim)
	);

	always @(posedge I_CLK) begin
		if (!I_RESETN) begin
			sync_a <= 4'h0;
			sync_b <= 4'h0;
		end else if (I_CE) begin
			sync_a <= {I_BACKUP_VALID, I_MAIN_PRESENT, I_MAIN_ABOVE_BACKUP, I_MAIN_ABOVE_PF};
			sync_b <= sync_a;
		end
	end

	always @* begin
		next_state = state;
		case (state)
			ST_WAIT: begin
				if (above_pf || I_ADDR_WRITE)
					next_state = ST_RUN;
			end
			ST_RUN: begin
				if (!use_main && I_OSC_DISABLE_CTL)
					next_state = ST_RETAIN;
				else if (!supply_ok)
					next_state = ST_WAIT;
			end
			ST_RETAIN: begin
				if (use_main || !I_OSC_DISABLE_CTL)
					next_state = ST_RUN;
			end
			default: next_state = ST_WAIT;
		endcase
	end

	always @(posedge I_CLK) begin
		if (!I_RESETN) begin
			state        <= ST_WAIT;
			sec_cnt      <= 32'h00000000;
			interval_cnt <= 4'h0;
			startup_cnt  <= 4'h0;
			startup_pend <= 1'b0;
			main_seen    <= 1'b0;
			hold_cnt     <= 32'h00000000;
			corr_pend    <= 1'b0;
			prev_pf      <= 1'b0;
			O_USE_MAIN   <= 1'b0;
			O_RESET_N    <= 1'b0;
			O_RESET_OE   <= 1'b0;
			O_OSC_RUN    <= 1'b0;
			O_TICK_1HZ   <= 1'b0;
			O_TEMP_START <= 1'b0;
			O_TRIM_LOAD  <= 1'b0;
			O_TRIM       <= 10'sh000;
			O_CAL_LOAD   <= 1'b0;
			O_CAL_SEC    <= `CAL_SEC_RST;
			O_CAL_MIN    <= `CAL_MIN_RST;
			O_CAL_HOUR   <= `CAL_HOUR_RST;
			O_CAL_DOW    <= `CAL_DOW_RST;
			O_CAL_DATE   <= `CAL_DATE_RST;
			O_CAL_MONTH  <= `CAL_MONTH_RST;
			O_CAL_YEAR   <= `CAL_YEAR_RST;
		end else if (I_CE) begin
			state        <= next_state;
			prev_pf      <= above_pf;
			O_USE_MAIN   <= use_main;
			O_OSC_RUN    <= (next_state == ST_RUN);
			O_TICK_1HZ   <= 1'b0;
			O_TEMP_START <= 1'b0;
			O_TRIM_LOAD  <= 1'b0;
			O_CAL_LOAD   <= 1'b0;

			if (state != ST_RUN)
				sec_cnt <= 32'h00000000;
			else if (sec_wrap)
				sec_cnt <= 32'h00000000;
			else
				sec_cnt <= sec_cnt + 32'h00000001;

			// calendar defaults on first main or address write on backup
			if ((above_pf && !main_seen) || (I_ADDR_WRITE && !use_main))
				O_CAL_LOAD <= 1'b1;
			if (above_pf)
				main_seen <= 1'b1;

			if ((above_pf && !prev_pf) || I_ADDR_WRITE) begin
				startup_pend <= 1'b1;
				startup_cnt  <= 4'h0;
			end else if (sec_wrap) begin
				O_TICK_1HZ <= 1'b1;
				if (startup_pend && startup_cnt + 4'h1 >= `STARTUP_DELAY_S) begin
					startup_pend <= 1'b0;
					interval_cnt <= 4'h0;
					O_TEMP_START <= 1'b1;
				end else if (interval_cnt + 4'h1 >= interval) begin
					interval_cnt <= 4'h0;
					O_TEMP_START <= 1'b1;
				end else begin
					interval_cnt <= interval_cnt + 4'h1;
				end
				if (startup_pend)
					startup_cnt <= startup_cnt + 4'h1;
			end

			// fold temperature into trim once conversion returns
			if (corr_pend && I_TEMP_DONE && state == ST_RUN) begin
				corr_pend   <= 1'b0;
				O_TRIM      <= sum_trim;
				O_TRIM_LOAD <= 1'b1;
			end
			// a new start in the same cycle as a done keeps the request
			if (O_TEMP_START)
				corr_pend <= 1'b1;

			// backup-only: pin disabled and pulled to the dead supply
			if (!main_in) begin
				O_RESET_N  <= 1'b0;
				O_RESET_OE <= 1'b0;
				hold_cnt   <= 32'h00000000;
			end else if (!above_pf) begin
				O_RESET_N  <= 1'b0;
				O_RESET_OE <= 1'b1;
				hold_cnt   <= 32'h00000000;
			// recovery hold, bypassed when stopped
			// look at next_state so that the starting edge already holds
			end else if (next_state != ST_RUN || at_limit(hold_cnt, RECOVERY_CYC + 1)) begin
				O_RESET_N  <= 1'b1;
				O_RESET_OE <= 1'b0;
			end else begin
				O_RESET_N  <= 1'b0;
				O_RESET_OE <= 1'b1;
				hold_cnt   <= hold_cnt + 32'h00000001;
			end
		end
	end
endmodule // rtc_power_timebase_control

// ==== bench/rtc_ptc_checker_asserts.sv ====
`timescale 1ns/1ps
module rtc_ptc_checker #(parameter SEC_CYCLES = 20, parameter RECOVERY_CYC = 8) (
	input wire logic I_CLK, I_RESETN, I_MAIN_ABOVE_PF, I_MAIN_ABOVE_BACKUP, I_MAIN_PRESENT, I_ADDR_WRITE,
	input wire logic I_OSC_DISABLE_CTL, I_TEMP_DONE, O_USE_MAIN, O_RESET_N, O_RESET_OE, O_OSC_RUN,
	input wire logic O_TICK_1HZ, O_TEMP_START, O_TRIM_LOAD, O_CAL_LOAD,
	input wire logic signed [7:0] I_AGING_OFFSET,
	input wire logic signed [9:0] I_FACTORY_TRIM, I_TEMP_TERM, O_TRIM,
	input wire logic [7:0] O_CAL_SEC, O_CAL_MIN, O_CAL_HOUR, O_CAL_DOW, O_CAL_DATE, O_CAL_MONTH, O_CAL_YEAR
);
	wire signed [11:0] sum = I_FACTORY_TRIM + I_AGING_OFFSET + I_TEMP_TERM;
	wire signed [9:0] sat = sum > 12'sh1FF ? 10'sh1FF : sum < -12'sh200 ? 10'sh200 : sum[9:0];
	default clocking @(posedge I_CLK); endclocking
	default disable iff (!I_RESETN);
	// sync takes two edges, output one more
	sequence pf_low; !I_MAIN_ABOVE_PF [*4]; endsequence
	sequence pf_high; I_MAIN_ABOVE_PF [*4]; endsequence
	reset_on_fail_a: assert property (pf_low |-> !O_RESET_N) else $error("reset pin not low");
	main_select_a: assert property (pf_high |-> O_USE_MAIN) else $error("main not selected");
	backup_select_a: assert property ((!I_MAIN_ABOVE_PF && !I_MAIN_ABOVE_BACKUP) [*4] |-> !O_USE_MAIN)
		else $error("backup not selected");
	backup_pin_a: assert property (!I_MAIN_PRESENT [*4] |-> !O_RESET_OE && !O_RESET_N)
		else $error("pin not disabled low");
	stopped_quiet_a: assert property (!O_OSC_RUN && !$past(O_OSC_RUN) |-> !(O_TICK_1HZ | O_TEMP_START | O_TRIM_LOAD))
		else $error("activity while stopped");
	trim_follow_a: assert property (O_TRIM_LOAD |-> $past(I_TEMP_DONE) && O_TRIM == $past(sat))
		else $error("trim load wrong");
	start_write_a: assert property (I_ADDR_WRITE && !I_OSC_DISABLE_CTL |=> O_OSC_RUN) else $error("no start");
	cal_default_a: assert property (O_CAL_LOAD |-> {O_CAL_DATE, O_CAL_MONTH, O_CAL_YEAR, O_CAL_DOW, O_CAL_HOUR,
		O_CAL_MIN, O_CAL_SEC} == 56'h01010001000000) else $error("calendar defaults wrong");
	tick_gap_a: assert property (O_TICK_1HZ |=> !O_TICK_1HZ [*8]) else $error("ticks too close");
	recovery_hold_a: assert property ($rose(O_RESET_N) && O_OSC_RUN |-> $past(I_MAIN_ABOVE_PF, 8))
		else $error("reset released early");
endmodule // rtc_ptc_checker
bind rtc_power_timebase_control rtc_ptc_checker #(.SEC_CYCLES(SEC_CYCLES), .RECOVERY_CYC(RECOVERY_CYC)) i_chk (.*);

// ==== bench/rtc_supply_model.sv ====
`timescale 1ns/1ps
module rtc_supply_model (
	input wire logic i_clk, i_start,
	input wire logic [1:0] i_lvl,
	output logic o_pf, o_ab, o_pr, o_done
);
	int n = 0;
	// level 0 absent, 1 under battery, 2 under threshold, 3 good
	assign o_pr = i_lvl != 2'h0;
	assign o_ab = i_lvl > 2'h1;
	assign o_pf = i_lvl == 2'h3;
	initial o_done = 1'b0;
	// conversion result four cycles after start
	always @(posedge i_clk) begin
		o_done <= n == 1;
		n <= i_start ? 3 : n > 0 ? n - 1 : 0;
	end
endmodule // rtc_supply_model

// ==== bench/rtc_power_timebase_control_tb.sv ====
`timescale 1ns/1ps
module rtc_power_timebase_control_tb;
	logic clk = 0, rst_n = 0, aw = 0, dis = 0, hit;
	logic [1:0] lvl = 2'h3;
	logic signed [7:0] ag = 8'sh00;
	logic signed [9:0] ft = 10'sh000, tt = 10'sh000;
	wire pf, ab, pr, done, um, rn, oe, run, tk, ts, tl, cl;
	wire signed [9:0] trim;
	int fail_count = 0, comparisons = 0, n;
	wire [5:0] p = {run, rn, cl, tl, ts, tk};
	always #12.5 clk = ~clk;
	rtc_supply_model i_sup (.i_clk(clk), .i_start(ts), .i_lvl(lvl), .o_pf(pf), .o_ab(ab), .o_pr(pr), .o_done(done));
	rtc_power_timebase_control #(.SEC_CYCLES(20), .RECOVERY_CYC(8)) i_dut (.I_CLK(clk), .I_RESETN(rst_n),
		.I_CE(1'b1), .I_MAIN_ABOVE_PF(pf), .I_MAIN_ABOVE_BACKUP(ab), .I_MAIN_PRESENT(pr), .I_BACKUP_VALID(1'b1),
		.I_ADDR_WRITE(aw), .I_OSC_DISABLE_CTL(dis), .I_AGING_OFFSET(ag), .I_FACTORY_TRIM(ft), .I_TEMP_DONE(done),
		.I_TEMP_TERM(tt), .O_USE_MAIN(um), .O_RESET_N(rn), .O_RESET_OE(oe), .O_OSC_RUN(run), .O_TICK_1HZ(tk),
		.O_TEMP_START(ts), .O_TRIM_LOAD(tl), .O_TRIM(trim), .O_CAL_LOAD(cl), .O_CAL_SEC(), .O_CAL_MIN(),
		.O_CAL_HOUR(), .O_CAL_DOW(), .O_CAL_DATE(), .O_CAL_MONTH(), .O_CAL_YEAR());
	function logic signed [9:0] et(input logic signed [11:0] s);
		return s > 12'sh1FF ? 10'sh1FF : s < -12'sh200 ? 10'sh200 : s[9:0];
	endfunction
	task chk(input logic [31:0] g, e);
		comparisons++;
		if (g !== e) begin
			fail_count++;
			$display("MISMATCH %0t got %0h expected %0h", $time, g, e);
		end
	endtask
	task give_verdict;
		if (fail_count == 0 && comparisons > 0)
			$display("TB: PASS");
		else
			$display("TB: FAIL");
		$finish;
	endtask
	// bounded wait on one strobe; a required one that never comes ends the run
	task wp(input int s, lim, input bit must);
		n = 0;
		do begin
			@(posedge clk);
			#1 n++;
		end while (p[s] !== 1'b1 && n < lim);
		hit = p[s] === 1'b1;
		if (must && !hit) begin
			fail_count++;
			give_verdict;
		end
	endtask
	task step(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask
	initial begin
		n = $urandom(32'hD06B);
		step(16);
		rst_n = 1;
		wp(3, 40, 1);
		wp(4, 40, 1); chk(n, 8);
		chk(um, 1);
		// on main the first conversion comes with the first tick, one second after start less the hold
		wp(1, 120, 1); chk(n, 20 - 8);
		for (int k = 0; k < 6; k++) begin
			wp(2, 60, 1); chk(trim, et(ft + ag + tt));
			if (k > 0) chk(n, 20);
			ag = k == 1 ? 8'sh7F : k == 2 ? 8'sh81 : 8'($urandom);
			ft = k == 1 ? 10'sh1F0 : k == 2 ? 10'sh210 : 10'($urandom);
			tt = 10'($urandom);
		end
		wp(1, 30, 1); wp(1, 30, 1); chk(n, 20);
		lvl = 2'h2; step(5); chk({um, rn}, 2'h2);
		lvl = 2'h1; step(5); chk(um, 0);
		wp(1, 250, 1); wp(1, 250, 1); chk(n, 200);
		wp(2, 250, 1); wp(2, 250, 1); chk(n, 200);
		lvl = 2'h0; step(5); chk({oe, rn}, 2'h0);
		dis = 1; step(10); chk(run, 0);
		wp(0, 100, 0); chk(hit, 0);
		dis = 0; aw = 1; step(1); aw = 0; chk(run, 1);
		chk(cl, 1);
		wp(1, 120, 1); chk(n > 30 && n < 50, 1);
		rst_n = 0; step(16); rst_n = 1;
		wp(5, 100, 0); chk(hit, 0);
		lvl = 2'h3; wp(5, 10, 1); wp(0, 30, 1); chk(run, 1);
		give_verdict;
	end
endmodule // rtc_power_timebase_control_tb
